// ### pkg/rtc_i2c_regs.vh
// constants of the two-wire slave interface of the real-time clock
// assumes a 25 MHz system clock; included by every design file that needs a figure
`ifndef RTC_I2C_REGS_VH
`define RTC_I2C_REGS_VH

// =============================================================
// bus addresses and framing
`define I2C_WR_ADDR 8'ha2
`define I2C_RD_ADDR 8'ha3
`define BYTE_BITS 4'h8
`define FIRST_SEND_BIT 4'h1

// =============================================================
// timing
`define SYS_CLK_KHZ 25000
`define WDOG_TIME_MS 1000
// one second of system clock cycles, sized to the watchdog counter
`define WDOG_CYCLES 25'h17d7840

// =============================================================
// register indices with defined reset bits
`define REG_CTRL1 4'h0
`define REG_CTRL2 4'h1
`define REG_SECONDS 4'h2
`define REG_MIN_ALARM 4'h9
`define REG_HOUR_ALARM 4'ha
`define REG_DAY_ALARM 4'hb
`define REG_WDAY_ALARM 4'hc
`define REG_CLKOUT 4'hd
`define REG_TIMER_CTRL 4'he

// =============================================================
// reset values and the masks of the bits that reset touches
`define RST_CTRL1 8'h08
`define RST_CTRL2 8'h00
`define MASK_ALL 8'hff
`define RST_MSB 8'h80
`define MASK_MSB 8'h80
`define RST_CLKOUT 8'h80
`define MASK_CLKOUT 8'h83
`define RST_TIMER_CTRL 8'h03
`define MASK_TIMER_CTRL 8'h83
`define MASK_NONE 8'h00

`endif

// ### hw/rtc_i2c_buf.v
// small first-in first-out buffer with valid and ready on both sides
// assumes one clock and a synchronous active-high reset from the parent
`timescale 1ns/1ps
`default_nettype none

module rtc_i2c_buf #(
	parameter DW = 12,
	parameter DEPTH = 2
) (
	input wire clk_in,
	input wire rst_in,
	input wire in_valid_in,
	input wire [DW-1:0] in_data_in,
	output wire in_ready_out,
	output wire out_valid_out,
	output wire [DW-1:0] out_data_out,
	input wire out_ready_in
);

	// =============================================================
	// storage: entry 0 is the head, one spare slot keeps shifts in range
	reg [DW-1:0] mem [0:DEPTH];
	reg [DEPTH:0] vld;
	integer i;

	function integer fill;
		input [DEPTH:0] v;
		integer k;
		begin
			fill = 0;
			for (k = 0; k < DEPTH; k = k + 1) begin
				fill = fill + v[k];
			end
		end
	endfunction

	wire pop = vld[0] & out_ready_in;
	wire push = in_valid_in & ~vld[DEPTH-1];
	wire [31:0] wpos = pop ? fill(vld) - 1 : fill(vld);

	assign in_ready_out = ~vld[DEPTH-1];
	assign out_valid_out = vld[0];
	assign out_data_out = mem[0];

	// =============================================================
	// shift toward the head on pop, write at the first free slot on push
	always @(posedge clk_in) begin
		if (rst_in) begin
			vld <= {(DEPTH+1){1'b0}};
		end else begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				if (pop) begin
					mem[i] <= mem[i+1];
					vld[i] <= vld[i+1];
				end
				if (push && wpos == i) begin
					mem[i] <= in_data_in;
					vld[i] <= 1'b1;
				end
			end
			vld[DEPTH] <= 1'b0;
			mem[DEPTH] <= {DW{1'b0}};
		end
	end

endmodule

`default_nettype wire

// ### hw/rtc_i2c_regmem.v
// sixteen eight-bit registers behind the word address pointer
// assumes a synchronous active-high reset; read data registered
`timescale 1ns/1ps
`default_nettype none
`include "rtc_i2c_regs.vh"

module rtc_i2c_regmem (
	input wire clk_in,
	input wire rst_in,
	input wire wr_en_in,
	input wire [3:0] wr_addr_in,
	input wire [7:0] wr_data_in,
	input wire [3:0] rd_addr_in,
	output reg [7:0] rd_data_out
);

	reg [7:0] mem [0:15];
	integer i;

	function [7:0] rst_mask;
		input [3:0] a;
		begin
			case (a)
				`REG_CTRL1, `REG_CTRL2: rst_mask = `MASK_ALL;
				`REG_SECONDS, `REG_MIN_ALARM, `REG_HOUR_ALARM: rst_mask = `MASK_MSB;
				`REG_DAY_ALARM, `REG_WDAY_ALARM: rst_mask = `MASK_MSB;
				`REG_CLKOUT: rst_mask = `MASK_CLKOUT;
				`REG_TIMER_CTRL: rst_mask = `MASK_TIMER_CTRL;
				default: rst_mask = `MASK_NONE;
			endcase
		end
	endfunction

	function [7:0] rst_val;
		input [3:0] a;
		begin
			case (a)
				`REG_CTRL1: rst_val = `RST_CTRL1;
				`REG_CTRL2: rst_val = `RST_CTRL2;
				`REG_SECONDS, `REG_MIN_ALARM, `REG_HOUR_ALARM: rst_val = `RST_MSB;
				`REG_DAY_ALARM, `REG_WDAY_ALARM: rst_val = `RST_MSB;
				`REG_CLKOUT: rst_val = `RST_CLKOUT;
				`REG_TIMER_CTRL: rst_val = `RST_TIMER_CTRL;
				default: rst_val = `MASK_NONE;
			endcase
		end
	endfunction

	// =============================================================
	// reset only touches defined bits; the rest keep their contents
	always @(posedge clk_in) begin
		if (rst_in) begin
			for (i = 0; i < 16; i = i + 1) begin
				mem[i] <= (mem[i] & ~rst_mask(i[3:0])) | rst_val(i[3:0]);
			end
			rd_data_out <= 8'h00;
		end else begin
			if (wr_en_in) begin
				mem[wr_addr_in] <= wr_data_in;
			end
			rd_data_out <= mem[rd_addr_in];
		end
	end

endmodule

`default_nettype wire

// ### hw/rtc_i2c_slave.v
// two-wire serial slave interface of the real-time clock, with access
// freeze and interface watchdog; holds the register file and a write stream
// assumes SCL and SDA come from pins and the oscillator-stop flag from the
// oscillator domain; the open-drain SDA wire is resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "rtc_i2c_regs.vh"

module rtc_i2c_slave #(
	parameter WDOG_W = 25,
	parameter [WDOG_W-1:0] WDOG_CYCLES = `WDOG_CYCLES,
	parameter BUF_DEPTH = 2
) (
	input wire SYS_CLK_IN,
	input wire RST_B_IN,
	input wire OSC_STOP_IN,
	input wire SCL_IN,
	input wire SDA_IN,
	output reg SDA_OUT,
	output reg SDA_OE_OUT,
	output reg FREEZE_OUT,
	output reg SEC_LOST_OUT,
	output wire WR_VALID_OUT,
	output wire [3:0] WR_ADDR_OUT,
	output wire [7:0] WR_DATA_OUT,
	input wire WR_READY_IN,
	input wire UPD_EN_IN,
	input wire [3:0] UPD_ADDR_IN,
	input wire [7:0] UPD_DATA_IN
);

	// =============================================================
	// states and fixed slave addresses
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_WORD = 4'h2;
	localparam [3:0] ST_DATA = 4'h3;
	localparam [3:0] ST_ACK = 4'h4;
	localparam [3:0] ST_SEND = 4'h5;
	localparam [3:0] ST_RACK = 4'h6;
	localparam [3:0] ST_WAIT = 4'h7;
	localparam [WDOG_W-1:0] WDOG_LAST = WDOG_CYCLES - 1'b1;
	localparam [7:0] WR_ADDR = `I2C_WR_ADDR;
	localparam [7:0] RD_ADDR = `I2C_RD_ADDR;

	function addr_hit;
		input [7:0] b;
		begin
			addr_hit = (b == WR_ADDR) || (b == RD_ADDR);
		end
	endfunction

	// =============================================================
	// pin synchronisers
	// the third stage of each pin only feeds the edge detectors
	reg scl_m, scl_s, scl_p;
	reg sda_m, sda_s, sda_p;
	reg osc_m, osc_s;

	always @(posedge SYS_CLK_IN) begin
		if (!RST_B_IN) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
			osc_m <= 1'b0;
			osc_s <= 1'b0;
		end else begin
			scl_m <= SCL_IN;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= SDA_IN;
			sda_s <= sda_m;
			sda_p <= sda_s;
			osc_m <= OSC_STOP_IN;
			osc_s <= osc_m;
		end
	end

	wire irst = ~RST_B_IN | osc_s;

	// =============================================================
	// bus events
	// clock only sampled
	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire start = scl_s & scl_p & sda_p & ~sda_s;
	wire stop = scl_s & scl_p & ~sda_p & sda_s;

	// =============================================================
	// interface state
	reg [3:0] state;
	reg [3:0] after;
	reg [3:0] cnt;
	reg [7:0] sr;
	reg [3:0] ptr;
	reg more;
	reg [WDOG_W-1:0] wdog;
	// one word waits here while the buffer is full; a later byte overwrites it
	reg pend;
	reg [11:0] pend_data;
	wire buf_in_ready;
	wire [7:0] rd_data;

	// =============================================================
	// interface watchdog; re-armed by every matched address
	wire wdog_done = FREEZE_OUT & (wdog == WDOG_LAST);

	always @(posedge SYS_CLK_IN) begin
		if (irst) begin
			state <= ST_IDLE;
			after <= ST_IDLE;
			cnt <= 4'h0;
			sr <= 8'h00;
			ptr <= 4'h0;
			more <= 1'b0;
			wdog <= {WDOG_W{1'b0}};
			pend <= 1'b0;
			pend_data <= 12'h000;
			SDA_OUT <= 1'b0;
			SDA_OE_OUT <= 1'b0;
			FREEZE_OUT <= 1'b0;
			SEC_LOST_OUT <= 1'b0;
		end else begin
			SEC_LOST_OUT <= 1'b0;
			if (pend && buf_in_ready) begin
				pend <= 1'b0;
			end
			if (FREEZE_OUT) begin
				wdog <= wdog + 1'b1;
			end
			if (wdog_done) begin
				state <= ST_IDLE;
				SDA_OE_OUT <= 1'b0;
				FREEZE_OUT <= 1'b0;
				SEC_LOST_OUT <= 1'b1;
			end else if (start) begin
				state <= ST_ADDR;
				cnt <= 4'h0;
				SDA_OE_OUT <= 1'b0;
			end else if (stop) begin
				state <= ST_IDLE;
				SDA_OE_OUT <= 1'b0;
				FREEZE_OUT <= 1'b0;
			end else begin
				case (state)
					ST_ADDR, ST_WORD, ST_DATA: begin
						if (scl_rise && cnt != `BYTE_BITS) begin
							sr <= {sr[6:0], sda_s};
							cnt <= cnt + 1'b1;
						end else if (scl_fall && cnt == `BYTE_BITS) begin
							cnt <= 4'h0;
							if (state == ST_ADDR) begin
								if (addr_hit(sr)) begin
									SDA_OE_OUT <= 1'b1;
									FREEZE_OUT <= 1'b1;
									wdog <= {WDOG_W{1'b0}};
									after <= sr[0] ? ST_SEND : ST_WORD;
									state <= ST_ACK;
								end else begin
									state <= ST_WAIT;
								end
							end else begin
								SDA_OE_OUT <= 1'b1;
								after <= ST_DATA;
								state <= ST_ACK;
								if (state == ST_WORD) begin
									ptr <= sr[3:0];
								end else begin
									pend <= 1'b1;
									pend_data <= {ptr, sr};
									ptr <= ptr + 1'b1;
								end
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							if (after == ST_SEND) begin
								sr <= rd_data;
								SDA_OE_OUT <= ~rd_data[7];
								cnt <= `FIRST_SEND_BIT;
							end else begin
								SDA_OE_OUT <= 1'b0;
							end
							state <= after;
						end
					end
					ST_SEND: begin
						if (scl_fall) begin
							if (cnt == `BYTE_BITS) begin
								SDA_OE_OUT <= 1'b0;
								state <= ST_RACK;
							end else begin
								SDA_OE_OUT <= ~sr[6];
								sr <= {sr[6:0], 1'b0};
								cnt <= cnt + 1'b1;
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							more <= ~sda_s;
							ptr <= ptr + 1'b1;
						end else if (scl_fall) begin
							if (more) begin
								sr <= rd_data;
								SDA_OE_OUT <= ~rd_data[7];
								cnt <= `FIRST_SEND_BIT;
								state <= ST_SEND;
							end else begin
								state <= ST_WAIT;
							end
						end
					end
					ST_WAIT, ST_IDLE: begin
						state <= state;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// =============================================================
	// write stream buffer and register file
	rtc_i2c_buf #(
		.DW(12),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_in(SYS_CLK_IN),
		.rst_in(irst),
		.in_valid_in(pend),
		.in_data_in(pend_data),
		.in_ready_out(buf_in_ready),
		.out_valid_out(WR_VALID_OUT),
		.out_data_out({WR_ADDR_OUT, WR_DATA_OUT}),
		.out_ready_in(WR_READY_IN)
	);

	// a drained bus write wins the register file over a same-cycle update
	wire drain = WR_VALID_OUT & WR_READY_IN;

	rtc_i2c_regmem u_mem (
		.clk_in(SYS_CLK_IN),
		.rst_in(irst),
		.wr_en_in(drain | UPD_EN_IN),
		.wr_addr_in(drain ? WR_ADDR_OUT : UPD_ADDR_IN),
		.wr_data_in(drain ? WR_DATA_OUT : UPD_DATA_IN),
		.rd_addr_in(ptr),
		.rd_data_out(rd_data)
	);

endmodule

`default_nettype wire

// ### bench/i2c_master_model.sv
// two-wire bus master model: drives the serial clock and data, reads the wire back
// assumes the bench resolves the data wire with a pull-up and feeds it to sda_in
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_out = b;
		w(3);
		scl_out = 1'b1;
		w(2);
		r = sda_in;
		w(1);
		scl_out = 1'b0;
		w(2);
	endtask
	task automatic start();
		sda_out = 1'b1;
		w(2);
		scl_out = 1'b1;
		w(3);
		sda_out = 1'b0;
		w(3);
		scl_out = 1'b0;
		w(2);
	endtask
	task automatic stop();
		sda_out = 1'b0;
		w(3);
		scl_out = 1'b1;
		w(3);
		sda_out = 1'b1;
		w(3);
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule
`default_nettype wire

// ### bench/rtc_i2c_slave_checker.sv
// port checks of the two-wire slave interface, bound into its top module
// assumes one system clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave_checker #(
	parameter WDOG_W = 25,
	parameter [WDOG_W-1:0] WDOG_CYCLES = 25'h17d7840
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic OSC_STOP_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE_OUT,
	input wire logic FREEZE_OUT,
	input wire logic SEC_LOST_OUT,
	input wire logic WR_VALID_OUT,
	input wire logic [3:0] WR_ADDR_OUT,
	input wire logic [7:0] WR_DATA_OUT,
	input wire logic WR_READY_IN
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	logic [31:0] frz_cnt;
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_B_IN || !FREEZE_OUT)
			frz_cnt <= 32'h0;
		else
			frz_cnt <= frz_cnt + 32'h1;
	end
	property p_low; !SDA_OUT; endproperty
	a_low: assert property (p_low) else $error("data pin driven high");
	property p_rst; $rose(RST_B_IN) |-> !SDA_OE_OUT && !FREEZE_OUT && !WR_VALID_OUT; endproperty
	a_rst: assert property (p_rst) else $error("busy after reset");
	property p_one; SEC_LOST_OUT |=> !SEC_LOST_OUT; endproperty
	a_one: assert property (p_one) else $error("loss pulse too long");
	property p_abort; SEC_LOST_OUT |-> !FREEZE_OUT && $past(FREEZE_OUT) && !SDA_OE_OUT; endproperty
	a_abort: assert property (p_abort) else $error("timeout left access open");
	property p_early; SEC_LOST_OUT |-> frz_cnt >= WDOG_CYCLES; endproperty
	a_early: assert property (p_early) else $error("timeout too early");
	property p_edge; $changed(SDA_OE_OUT) && !SEC_LOST_OUT |-> !SCL_IN; endproperty
	a_edge: assert property (p_edge) else $error("data moved with clock high");
	property p_ack; SDA_OE_OUT && $rose(SCL_IN) |-> SDA_OE_OUT [*3]; endproperty
	a_ack: assert property (p_ack) else $error("pull-down dropped in high");
	property p_stop; SCL_IN && $rose(SDA_IN) |-> ##[1:6] !FREEZE_OUT; endproperty
	a_stop: assert property (p_stop) else $error("stop did not end access");
	property p_osc; OSC_STOP_IN [*5] |-> !SDA_OE_OUT && !FREEZE_OUT; endproperty
	a_osc: assert property (p_osc) else $error("bus used while stopped");
	property p_hold;
		WR_VALID_OUT && !WR_READY_IN |=> WR_VALID_OUT && $stable(WR_DATA_OUT) && $stable(WR_ADDR_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word lost");
	c_lost: cover property (SEC_LOST_OUT);
	c_take: cover property (WR_VALID_OUT && WR_READY_IN);
	c_ack: cover property ($rose(SDA_OE_OUT));
endmodule
bind rtc_i2c_slave rtc_i2c_slave_checker #(.WDOG_W(WDOG_W), .WDOG_CYCLES(WDOG_CYCLES)) chk_u (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .OSC_STOP_IN(OSC_STOP_IN),
	.SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT),
	.FREEZE_OUT(FREEZE_OUT), .SEC_LOST_OUT(SEC_LOST_OUT), .WR_VALID_OUT(WR_VALID_OUT),
	.WR_ADDR_OUT(WR_ADDR_OUT), .WR_DATA_OUT(WR_DATA_OUT), .WR_READY_IN(WR_READY_IN)
);
`default_nettype wire

// ### bench/test_rtc_i2c_slave.sv
// self-checking bench of the two-wire slave interface
// assumes the master model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_rtc_i2c_slave;
	localparam int WD = 600;
	logic clk, rst_b, osc, rdy, upd, a;
	logic [3:0] upd_a;
	logic [7:0] upd_d, d;
	wire scl, sda_m, oe, sda_o, frz, lost, wv;
	wire [3:0] wa;
	wire [7:0] wdat;
	wire sda = sda_m & ~oe;
	int mismatches, n_checks;
	rtc_i2c_slave #(.WDOG_W(25), .WDOG_CYCLES(25'(WD))) dut_u (
		.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .OSC_STOP_IN(osc), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(oe), .FREEZE_OUT(frz),
		.SEC_LOST_OUT(lost), .WR_VALID_OUT(wv), .WR_ADDR_OUT(wa), .WR_DATA_OUT(wdat),
		.WR_READY_IN(rdy), .UPD_EN_IN(upd), .UPD_ADDR_IN(upd_a), .UPD_DATA_IN(upd_d)
	);
	i2c_master_model mst_u (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic give_up();
		mismatches++;
		end_of_test();
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({7'h0, got}, {7'h0, exp});
	endtask
	task automatic open_at(input logic [7:0] ad, input logic nak);
		mst_u.start();
		mst_u.wr(ad, a);
		chkb(a, nak);
	endtask
	task automatic t_reset();
		open_at(8'ha3, 1'b0);
		mst_u.rd(1'b0, d);
		chk(d, 8'h08);
		mst_u.rd(1'b1, d);
		chk(d, 8'h00);
		mst_u.stop();
		cyc(2);
		chkb(frz, 1'b0);
		chkb(sda_o, 1'b0);
	endtask
	task automatic t_write();
		logic [7:0] dat [3];
		int k;
		dat = '{8'h5a, 8'hc3, 8'h77};
		open_at(8'ha2, 1'b0);
		mst_u.wr(8'hf3, a);
		chkb(frz, 1'b1);
		for (int i = 0; i < 3; i++) begin
			mst_u.wr(dat[i], a);
			chkb(a, 1'b0);
		end
		mst_u.stop();
		cyc(2);
		chkb(frz, 1'b0);
		for (int i = 0; i < 3; i++) begin
			k = 0;
			while (wv !== 1'b1 && k < 20) begin
				cyc(1);
				k++;
			end
			if (k == 20)
				give_up();
			chk({4'h0, wa}, 8'h03 + 8'(i));
			chk(wdat, dat[i]);
			rdy = 1'b1;
			cyc(1);
			rdy = 1'b0;
		end
		cyc(2);
		chkb(wv, 1'b0);
	endtask
	task automatic t_read();
		logic [7:0] exp [4];
		exp = '{8'h5a, 8'hc3, 8'h77, 8'h81};
		upd_a = 4'h6;
		upd_d = 8'h81;
		upd = 1'b1;
		cyc(1);
		upd = 1'b0;
		open_at(8'ha2, 1'b0);
		mst_u.wr(8'h03, a);
		chkb(a, 1'b0);
		open_at(8'ha3, 1'b0);
		for (int i = 0; i < 4; i++) begin
			mst_u.rd(i == 3, d);
			chk(d, exp[i]);
		end
		chkb(sda, 1'b1);
		chkb(frz, 1'b1);
		mst_u.stop();
	endtask
	task automatic t_bad();
		open_at(8'ha4, 1'b1);
		chkb(frz, 1'b0);
		mst_u.wr(8'ha2, a);
		chkb(a, 1'b1);
		mst_u.stop();
	endtask
	task automatic t_wdog();
		int k;
		open_at(8'ha2, 1'b0);
		k = 0;
		while (lost !== 1'b1 && k < 2 * WD) begin
			cyc(1);
			k++;
		end
		if (k == 2 * WD)
			give_up();
		chkb(k > WD - 30 && k <= WD, 1'b1);
		chkb(frz, 1'b0);
		mst_u.wr(8'h00, a);
		chkb(a, 1'b1);
		mst_u.stop();
	endtask
	task automatic t_osc();
		osc = 1'b1;
		cyc(4);
		open_at(8'ha2, 1'b1);
		mst_u.stop();
		osc = 1'b0;
		cyc(4);
		open_at(8'ha3, 1'b0);
		mst_u.rd(1'b1, d);
		chk(d, 8'h08);
		mst_u.stop();
		cyc(2);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		osc = 1'b0;
		rdy = 1'b0;
		upd = 1'b0;
		upd_a = 4'h0;
		upd_d = 8'h00;
		mismatches = 0;
		n_checks = 0;
		cyc(2);
		rst_b = 1'b1;
		cyc(4);
		t_reset();
		t_write();
		t_read();
		t_bad();
		t_wdog();
		t_osc();
		end_of_test();
	end
endmodule
`default_nettype wire
